// File: core/tssc_cfg_latch.sv
// Capture stage for the two configuration words.
// Assumes the words are steady around power-on reset release.
`timescale 1ns/100ps
module tssc_cfg_latch
	import tssc_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	input  wire logic [15:0] startup_cfg_in,
	input  wire logic [15:0] osc_cfg_in,
	output logic      [15:0] startup_cfg_out,
	output logic      [15:0] osc_cfg_out,
	output logic             valid_out
);

	// ------------------------------------------------------------------
	// Sample once after reset release and hold
	// ------------------------------------------------------------------

	// Takes the words on the first edge after release, then freezes them.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			startup_cfg_out <= 16'h0000;
			osc_cfg_out     <= 16'h0000;
			valid_out       <= 1'b0;
		end else if (!valid_out) begin
			startup_cfg_out <= startup_cfg_in & TSSC_MASK_STARTUP_CFG;
			osc_cfg_out     <= osc_cfg_in & TSSC_MASK_OSC_CFG;
			valid_out       <= 1'b1;
		end
	end

endmodule

// File: core/tssc_pkg.sv
// Package for the two-speed start-up clock select block.
// Assumes one 25 MHz clock and a plain register port with word indices.
package tssc_pkg;

	// ------------------------------------------------------------------
	// Register indices on the plain register port
	// ------------------------------------------------------------------
	localparam logic [2:0] TSSC_IDX_OSC_CONTROL_STATUS    = 3'h0;
	localparam logic [2:0] TSSC_IDX_CLOCK_DIVIDER_CONTROL = 3'h1;
	localparam logic [2:0] TSSC_IDX_PLL_FEEDBACK_DIVISOR  = 3'h2;
	localparam logic [2:0] TSSC_IDX_RC_TUNING             = 3'h3;
	localparam logic [2:0] TSSC_IDX_STARTUP_SOURCE_CONFIG = 3'h4;
	localparam logic [2:0] TSSC_IDX_OSCILLATOR_CONFIG     = 3'h5;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [15:0] TSSC_RST_CLOCK_DIVIDER  = 16'h3040;
	localparam logic [15:0] TSSC_RST_PLL_FEEDBACK   = 16'h0030;
	localparam logic [15:0] TSSC_RST_RC_TUNING      = 16'h0000;
	localparam logic [15:0] TSSC_RST_OSC_CONTROL    = 16'h7700;

	// ------------------------------------------------------------------
	// Implemented-bit masks (unimplemented bits read as zero)
	// ------------------------------------------------------------------
	localparam logic [15:0] TSSC_MASK_CLOCK_DIVIDER = 16'hffdf;
	localparam logic [15:0] TSSC_MASK_PLL_FEEDBACK  = 16'h01ff;
	localparam logic [15:0] TSSC_MASK_RC_TUNING     = 16'h003f;
	localparam logic [15:0] TSSC_MASK_STARTUP_CFG   = 16'h00a7;
	localparam logic [15:0] TSSC_MASK_OSC_CFG       = 16'h00e7;

	// ------------------------------------------------------------------
	// Field positions in the oscillator control and status register
	// ------------------------------------------------------------------
	localparam int TSSC_POS_CURRENT_LO  = 12;
	localparam int TSSC_POS_NEW_LO      = 8;
	localparam int TSSC_POS_LOCKOUT     = 7;
	localparam int TSSC_POS_PIN_LOCK    = 6;
	localparam int TSSC_POS_PLL_LOCK    = 5;
	localparam int TSSC_POS_FAIL        = 3;
	localparam int TSSC_POS_SEC_OSC_EN  = 1;
	localparam int TSSC_POS_SWITCH_REQ  = 0;

	// Configuration word fields.
	localparam int TSSC_POS_TWO_SPEED   = 7;
	localparam int TSSC_POS_MONITOR_HI  = 7;
	localparam int TSSC_POS_MONITOR_LO  = 6;

	// ------------------------------------------------------------------
	// Clock source encodings and RC trim codes
	// ------------------------------------------------------------------
	localparam logic [2:0] TSSC_SRC_INTERNAL_FAST_RC = 3'h0;
	localparam logic [2:0] TSSC_SRC_RC_PLL           = 3'h1;
	localparam logic [2:0] TSSC_SRC_PRIMARY          = 3'h2;
	localparam logic [2:0] TSSC_SRC_PRIMARY_PLL      = 3'h3;
	localparam logic [2:0] TSSC_SRC_SECONDARY        = 3'h4;
	localparam logic [5:0] TSSC_TRIM_PLUS_11P625     = 6'h1f;
	localparam logic [5:0] TSSC_TRIM_PLUS_11P25      = 6'h1e;

	// ------------------------------------------------------------------
	// Timing: clock-stable settle time after ready
	// ------------------------------------------------------------------
	localparam int TSSC_CLK_MHZ         = 25;
	localparam int TSSC_SETTLE_NS       = 200;
	localparam int TSSC_SETTLE_CYCLES   = (TSSC_SETTLE_NS * TSSC_CLK_MHZ + 999) / 1000;

	typedef enum logic [1:0] {
		TSSC_ST_IDLE,
		TSSC_ST_WAIT_READY,
		TSSC_ST_SETTLE,
		TSSC_ST_DONE
	} tssc_state_e;

endpackage

// File: core/tssc_top.sv
// Two-speed start-up clock select and oscillator register set.
// Assumes rst_n_in is the power-on reset, oscillator ready and PLL lock
// inputs are synchronous to mclk_in, and the register port is a plain strobe port.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps

module tssc_top
	import tssc_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	input  wire logic [2:0]  reg_addr_in,
	input  wire logic [15:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [15:0] reg_rdata_out,
	input  wire logic [15:0] startup_source_config_in,
	input  wire logic [15:0] oscillator_config_in,
	input  wire logic        osc_startup_timer_done_in,
	input  wire logic        pll_locked_in,
	input  wire logic        pll_lock_wait_enable_in,
	output logic [2:0]       current_source_status_out,
	output logic             internal_fast_rc_enable_out,
	output logic             target_osc_enable_out,
	output logic             core_run_out,
	output logic             startup_done_out,
	output logic [5:0]       rc_trim_field_out,
	output logic [6:0]       rc_trim_pct_x8_out
);
	import tssc_pkg::*;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [15:0] startup_cfg;
	logic [15:0] osc_cfg;
	logic        cfg_valid;
	tssc_state_e state_reg;
	tssc_state_e state_next;
	logic [2:0]  current_reg;
	logic [2:0]  new_source_reg;
	logic        switch_request_reg;
	logic        pll_lock_reg;
	logic        lockout_reg;
	logic        pin_lock_reg;
	logic        sec_osc_en_reg;
	logic        rc_on_reg;
	logic        old_off_reg;
	logic [15:0] clock_divider_control_reg;
	logic [15:0] pll_feedback_divisor_reg;
	logic [15:0] rctun_reg;
	logic [7:0]  settle_cnt_reg;
	logic        two_speed;
	logic [2:0]  cfg_source;
	logic        monitor_on;
	logic        switching_on;
	logic        needs_pll;
	logic        is_crystal;
	logic        target_ready;
	logic [15:0] osc_control_status;
	logic [15:0] rdata_next;

	// ------------------------------------------------------------------
	// Configuration capture
	// ------------------------------------------------------------------

	// Holds the two configuration words from power-on for the whole sequence.
	tssc_cfg_latch u_cfg (
		.mclk_in         (mclk_in),
		.rst_n_in        (rst_n_in),
		.startup_cfg_in  (startup_source_config_in),
		.osc_cfg_in      (oscillator_config_in),
		.startup_cfg_out (startup_cfg),
		.osc_cfg_out     (osc_cfg),
		.valid_out       (cfg_valid)
	);

	// Decodes the captured words; two-speed is enabled high, switching and monitor low.
	assign two_speed    = startup_cfg[TSSC_POS_TWO_SPEED];
	assign cfg_source   = startup_cfg[2:0];
	assign switching_on = !osc_cfg[TSSC_POS_MONITOR_HI];
	assign monitor_on   = switching_on && !osc_cfg[TSSC_POS_MONITOR_LO];
	assign needs_pll    = (cfg_source == TSSC_SRC_RC_PLL) || (cfg_source == TSSC_SRC_PRIMARY_PLL);
	assign is_crystal   = (cfg_source == TSSC_SRC_PRIMARY) || (cfg_source == TSSC_SRC_PRIMARY_PLL)
	                      || (cfg_source == TSSC_SRC_SECONDARY);

	// Target is ready when the timer ran out for crystals and PLL locked if needed and lock wait is enabled.
	assign target_ready = (!is_crystal || osc_startup_timer_done_in)
	                      && (!needs_pll || pll_locked_in || !pll_lock_wait_enable_in);

	// ------------------------------------------------------------------
	// Start-up sequencer
	// ------------------------------------------------------------------

	// Picks the next step; the monitor/switch field is not consulted here.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			TSSC_ST_IDLE: begin
				if (cfg_valid) begin
					if (two_speed && cfg_source != TSSC_SRC_INTERNAL_FAST_RC) begin
						state_next = TSSC_ST_WAIT_READY;
					end else begin
						state_next = TSSC_ST_DONE;
					end
				end
			end
			TSSC_ST_WAIT_READY: begin
				if (target_ready) begin
					state_next = TSSC_ST_SETTLE;
				end
			end
			TSSC_ST_SETTLE: begin
				if (!target_ready) begin
					state_next = TSSC_ST_WAIT_READY;
				end else if (settle_cnt_reg == 8'(TSSC_SETTLE_CYCLES - 1)) begin
					state_next = TSSC_ST_DONE;
				end
			end
			TSSC_ST_DONE: begin
				state_next = TSSC_ST_DONE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= TSSC_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Counts the stabilisation wait once the target reports ready.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			settle_cnt_reg <= 8'h00;
		end else if (state_reg == TSSC_ST_SETTLE) begin
			settle_cnt_reg <= settle_cnt_reg + 8'h01;
		end else begin
			settle_cnt_reg <= 8'h00;
		end
	end

	// ------------------------------------------------------------------
	// Source fields and switch request
	// ------------------------------------------------------------------

	// Current source starts on internal RC; new source loads the configured one.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			current_reg        <= TSSC_SRC_INTERNAL_FAST_RC;
			new_source_reg     <= TSSC_SRC_INTERNAL_FAST_RC;
			switch_request_reg <= 1'b0;
		end else if (state_reg == TSSC_ST_IDLE && cfg_valid) begin
			new_source_reg <= cfg_source;
			if (two_speed) begin
				current_reg        <= TSSC_SRC_INTERNAL_FAST_RC;
				switch_request_reg <= (cfg_source != TSSC_SRC_INTERNAL_FAST_RC);
			end else begin
				current_reg <= cfg_source;
			end
		end else if (state_reg == TSSC_ST_SETTLE && state_next == TSSC_ST_DONE) begin
			current_reg        <= new_source_reg;
			switch_request_reg <= 1'b0;
		end
	end

	// Internal RC runs until the switch ends, then stops unless the monitor is on or the new source is RC with PLL; without two-speed only RC sources keep it.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rc_on_reg   <= 1'b1;
			old_off_reg <= 1'b0;
		end else if (state_reg == TSSC_ST_IDLE && cfg_valid) begin
			rc_on_reg <= two_speed || cfg_source == TSSC_SRC_INTERNAL_FAST_RC || cfg_source == TSSC_SRC_RC_PLL;
		end else if (state_reg == TSSC_ST_SETTLE && state_next == TSSC_ST_DONE) begin
			rc_on_reg   <= monitor_on || needs_pll && cfg_source == TSSC_SRC_RC_PLL;
			old_off_reg <= !monitor_on;
		end
	end

	// PLL lock status bit follows the lock input.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pll_lock_reg <= 1'b0;
		end else begin
			pll_lock_reg <= pll_locked_in;
		end
	end

	// ------------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------------

	// Writable control bits; lockout only sets and is cleared by power-on, pin lock follows each write.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clock_divider_control_reg     <= TSSC_RST_CLOCK_DIVIDER;
			pll_feedback_divisor_reg     <= TSSC_RST_PLL_FEEDBACK;
			rctun_reg      <= TSSC_RST_RC_TUNING;
			lockout_reg    <= 1'b0;
			pin_lock_reg   <= 1'b0;
			sec_osc_en_reg <= 1'b0;
		end else if (reg_wr_in) begin
			unique case (reg_addr_in)
				TSSC_IDX_CLOCK_DIVIDER_CONTROL: begin
					clock_divider_control_reg <= reg_wdata_in & TSSC_MASK_CLOCK_DIVIDER;
				end
				TSSC_IDX_PLL_FEEDBACK_DIVISOR: begin
					pll_feedback_divisor_reg <= reg_wdata_in & TSSC_MASK_PLL_FEEDBACK;
				end
				TSSC_IDX_RC_TUNING: begin
					rctun_reg <= reg_wdata_in & TSSC_MASK_RC_TUNING;
				end
				TSSC_IDX_OSC_CONTROL_STATUS: begin
					lockout_reg    <= lockout_reg | reg_wdata_in[TSSC_POS_LOCKOUT];
					pin_lock_reg   <= reg_wdata_in[TSSC_POS_PIN_LOCK];
					sec_osc_en_reg <= reg_wdata_in[TSSC_POS_SEC_OSC_EN];
				end
				default: begin
				end
			endcase
		end
	end

	// Assembles the control and status word; unused bits are zero.
	always_comb begin
		osc_control_status = 16'h0000;
		osc_control_status[TSSC_POS_CURRENT_LO +: 3] = current_reg;
		osc_control_status[TSSC_POS_NEW_LO +: 3]     = new_source_reg;
		osc_control_status[TSSC_POS_LOCKOUT]         = lockout_reg;
		osc_control_status[TSSC_POS_PIN_LOCK]        = pin_lock_reg;
		osc_control_status[TSSC_POS_PLL_LOCK]        = pll_lock_reg;
		osc_control_status[TSSC_POS_SEC_OSC_EN]      = sec_osc_en_reg;
		osc_control_status[TSSC_POS_SWITCH_REQ]      = switch_request_reg;
	end

	// Read mux; unmapped indices return zero.
	always_comb begin
		unique case (reg_addr_in)
			TSSC_IDX_OSC_CONTROL_STATUS:    rdata_next = osc_control_status;
			TSSC_IDX_CLOCK_DIVIDER_CONTROL: rdata_next = clock_divider_control_reg;
			TSSC_IDX_PLL_FEEDBACK_DIVISOR:  rdata_next = pll_feedback_divisor_reg;
			TSSC_IDX_RC_TUNING:             rdata_next = rctun_reg;
			TSSC_IDX_STARTUP_SOURCE_CONFIG: rdata_next = startup_cfg;
			TSSC_IDX_OSCILLATOR_CONFIG:     rdata_next = osc_cfg;
			default:                        rdata_next = 16'h0000;
		endcase
	end

	// Read data stands in the cycle after the strobe only.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rdata_next;
		end else begin
			reg_rdata_out <= 16'h0000;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------

	// Trim code and its effect in eighths of a percent for the two top codes.
	always_comb begin
		unique case (rctun_reg[5:0])
			TSSC_TRIM_PLUS_11P625: rc_trim_pct_x8_out = 7'h5d;
			TSSC_TRIM_PLUS_11P25:  rc_trim_pct_x8_out = 7'h5a;
			default:               rc_trim_pct_x8_out = 7'h00;
		endcase
	end

	assign rc_trim_field_out           = rctun_reg[5:0];
	assign current_source_status_out   = current_reg;
	assign internal_fast_rc_enable_out = rc_on_reg;
	assign target_osc_enable_out       = (state_reg != TSSC_ST_IDLE) && !old_off_reg || state_reg == TSSC_ST_DONE;
	assign core_run_out                = 1'b1;
	assign startup_done_out            = (state_reg == TSSC_ST_DONE);

endmodule

// File: tb/tssc_checker.sv
// Concurrent checks for the two-speed start-up clock select block.
// Assumes it is bound to tssc_top and sees only that module's ports.
`timescale 1ns/100ps
module tssc_checker (
	input wire logic        mclk_in,
	input wire logic        rst_n_in,
	input wire logic [2:0]  reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic [15:0] startup_source_config_in,
	input wire logic [15:0] oscillator_config_in,
	input wire logic        osc_startup_timer_done_in,
	input wire logic        pll_locked_in,
	input wire logic        pll_lock_wait_enable_in,
	input wire logic [2:0]  current_source_status_out,
	input wire logic        internal_fast_rc_enable_out,
	input wire logic        target_osc_enable_out,
	input wire logic        core_run_out,
	input wire logic        startup_done_out,
	input wire logic [5:0]  rc_trim_field_out,
	input wire logic [6:0]  rc_trim_pct_x8_out
);
	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	// All checks run on the one clock and pause during power-on reset.
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	property p_core_runs; core_run_out == 1'b1; endproperty
	a_core_runs: assert property (p_core_runs) else $error("core stopped");
	property p_rc_on_until_done; !startup_done_out |-> internal_fast_rc_enable_out; endproperty
	a_rc_on_until_done: assert property (p_rc_on_until_done) else $error("rc off early");
	property p_rc_off_only_after_switch;
		!internal_fast_rc_enable_out |-> startup_done_out && current_source_status_out != 3'h0;
	endproperty
	a_rc_off_only_after_switch: assert property (p_rc_off_only_after_switch) else $error("rc off wrongly");
	property p_done_holds; startup_done_out |=> startup_done_out; endproperty
	a_done_holds: assert property (p_done_holds) else $error("done dropped");
	property p_source_moves_at_done; $changed(current_source_status_out) |-> startup_done_out; endproperty
	a_source_moves_at_done: assert property (p_source_moves_at_done) else $error("source moved early");
	property p_timer_wait;
		$rose(startup_done_out) && current_source_status_out inside {3'h2, 3'h3, 3'h4}
			|-> $past(osc_startup_timer_done_in, 5);
	endproperty
	a_timer_wait: assert property (p_timer_wait) else $error("switched before timer");
	property p_lock_wait;
		$rose(startup_done_out) && current_source_status_out inside {3'h1, 3'h3} && pll_lock_wait_enable_in
			|-> $past(pll_locked_in, 5);
	endproperty
	a_lock_wait: assert property (p_lock_wait) else $error("switched before lock");
	property p_trim_pct;
		rc_trim_pct_x8_out == (rc_trim_field_out == 6'h1f ? 7'h5d : rc_trim_field_out == 6'h1e ? 7'h5a : 7'h00);
	endproperty
	a_trim_pct: assert property (p_trim_pct) else $error("trim percent wrong");
	property p_trim_write;
		reg_wr_in && reg_addr_in == 3'h3 |=> {10'h000, rc_trim_field_out} == ($past(reg_wdata_in) & 16'h003f);
	endproperty
	a_trim_write: assert property (p_trim_write) else $error("trim not written");
	property p_rdata_idle; !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
	property p_unmapped_zero; reg_rd_in && reg_addr_in > 3'h5 |=> reg_rdata_out == 16'h0000; endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

	// Main scenarios that the bench is expected to reach.
	c_switch: cover property ($rose(startup_done_out) && current_source_status_out != 3'h0);
	c_trim_top: cover property (rc_trim_field_out == 6'h1f);
	c_cfg_read: cover property (reg_rd_in && reg_addr_in == 3'h4);
endmodule

bind tssc_top tssc_checker u_checker (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.startup_source_config_in(startup_source_config_in), .oscillator_config_in(oscillator_config_in),
	.osc_startup_timer_done_in(osc_startup_timer_done_in), .pll_locked_in(pll_locked_in),
	.pll_lock_wait_enable_in(pll_lock_wait_enable_in), .current_source_status_out(current_source_status_out),
	.internal_fast_rc_enable_out(internal_fast_rc_enable_out), .target_osc_enable_out(target_osc_enable_out),
	.core_run_out(core_run_out), .startup_done_out(startup_done_out), .rc_trim_field_out(rc_trim_field_out),
	.rc_trim_pct_x8_out(rc_trim_pct_x8_out));

// File: tb/tssc_tb_top.sv
// Self-checking bench for the two-speed start-up clock select block.
// Assumes tssc_top and tssc_pkg are compiled first; the bench drives every port.
`timescale 1ns/100ps
module two_speed_startup_clock_select_tb_top;
	import tssc_pkg::*;
	logic        mclk_in, rst_n_in, reg_wr_in, reg_rd_in, timer_done, pll_locked, lock_wait;
	logic [2:0]  reg_addr_in, current_src, src;
	logic [15:0] reg_wdata_in, reg_rdata_out, scfg, ocfg, startup_cfg, osc_cfg, rd_val, d;
	logic        rc_en, tgt_en, core_run, done, seen, need;
	logic [5:0]  trim_field, t;
	logic [6:0]  trim_pct;
	logic [31:0] lfsr_reg, r;
	int          err_count, n_compared, i, k;
	int          cyc = 0;

	tssc_top dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.startup_source_config_in(startup_cfg), .oscillator_config_in(osc_cfg), .osc_startup_timer_done_in(timer_done),
		.pll_locked_in(pll_locked), .pll_lock_wait_enable_in(lock_wait), .current_source_status_out(current_src),
		.internal_fast_rc_enable_out(rc_en), .target_osc_enable_out(tgt_en), .core_run_out(core_run),
		.startup_done_out(done), .rc_trim_field_out(trim_field), .rc_trim_pct_x8_out(trim_pct));

	// Free-running 25 MHz clock.
	initial begin
		mclk_in = 1'b0;
		forever #20 mclk_in = ~mclk_in;
	end

	// Ends the run with the verdict.
	task automatic conclude;
		if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// Cuts a hung run short well beyond the expected run of under a thousand cycles.
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			conclude();
		end
	end

	// Next pseudo-random word from the feedback register.
	function automatic void rnd(output logic [31:0] v);
		lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
		v = lfsr_reg;
	endfunction

	// Readable bits of the divider, feedback and tuning registers; the rest must read as zero.
	function automatic logic [15:0] rd_mask(input int idx);
		return idx == 1 ? 16'hffdf : idx == 2 ? 16'h01ff : 16'h003f;
	endfunction

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask

	task automatic reg_wr(input logic [2:0] a, input logic [15:0] v);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic reg_rd(input logic [2:0] a, output logic [15:0] v);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
		@(negedge mclk_in);
		v = reg_rdata_out;
	endtask

	// Power-on reset for 12 cycles with the given configuration words.
	task automatic do_reset(input logic [15:0] sc, input logic [15:0] oc);
		@(posedge mclk_in);
		rst_n_in <= 1'b0;
		startup_cfg <= sc;
		osc_cfg <= oc;
		timer_done <= 1'b0;
		pll_locked <= 1'b0;
		repeat (12) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
	endtask

	// Watches for completion over a bounded number of cycles.
	task automatic wait_done(output logic s);
		s = 1'b0;
		repeat (20) begin
			@(negedge mclk_in);
			if (done === 1'b1) s = 1'b1;
		end
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		{rst_n_in, reg_wr_in, reg_rd_in, timer_done, pll_locked, lock_wait} = 6'h00;
		{reg_addr_in, reg_wdata_in, startup_cfg, osc_cfg} = '0;
		lfsr_reg = 32'h0581;
		err_count = 0;
		n_compared = 0;
		do_reset(16'h00a2, 16'h00c5);
		reg_rd(3'h1, rd_val); check("divider reset", 16'h3040, rd_val);
		reg_rd(3'h2, rd_val); check("feedback reset", 16'h0030, rd_val);
		reg_rd(3'h3, rd_val); check("tuning reset", 16'h0000, rd_val);
		// Write all ones, all zeros and random words to the divider, feedback and tuning registers.
		for (i = 1; i < 4; i++) begin
			for (k = 0; k < 3; k++) begin
				rnd(r);
				d = k == 0 ? 16'hffff : k == 1 ? 16'h0000 : r[15:0];
				reg_wr(i[2:0], d);
				reg_rd(i[2:0], rd_val); check("register readback", d & rd_mask(i), rd_val);
			end
		end
		// Configuration words are read-only and unmapped places read as zero.
		reg_wr(3'h4, 16'h0000);
		reg_rd(3'h4, rd_val); check("startup config", 16'h00a2, rd_val);
		reg_rd(3'h5, rd_val); check("osc config", 16'h00c5, rd_val);
		reg_wr(3'h6, 16'hffff);
		reg_rd(3'h7, rd_val); check("unmapped read", 16'h0000, rd_val);
		// Trim codes: both documented steps and a code outside them.
		for (k = 0; k < 3; k++) begin
			rnd(r);
			t = k == 0 ? 6'h1f : k == 1 ? 6'h1e : {1'b1, r[4:0]};
			reg_wr(3'h3, {r[15:6], t});
			@(negedge mclk_in);
			check("trim field", {10'h000, t}, {10'h000, trim_field});
			check("trim percent", k == 0 ? 16'h005d : k == 1 ? 16'h005a : 16'h0000, {9'h000, trim_pct});
		end
		// Start-up runs over sources, monitor settings and lock-wait choices.
		for (k = 0; k < 8; k++) begin
			rnd(r);
			src = k == 0 ? 3'h0 : 3'h1 + {1'b0, r[1:0]};
			@(posedge mclk_in);
			lock_wait <= r[4];
			scfg = {8'h00, 3'b101, 2'b00, src}; // Reserved bit 5 programmed as one.
			ocfg = {8'h00, k[1:0], r[5:0]};
			do_reset(scfg, ocfg);
			startup_cfg <= r[31:16];
			osc_cfg <= ~ocfg;
			reg_rd(3'h0, rd_val);
			check("current before switch", 16'h0000, {13'h0, current_src});
			check("control before switch", {5'h00, src, 7'h00, src != 3'h0}, rd_val & 16'hff15);
			wait_done(seen);
			if (src != 3'h0) begin
				check("switch without timer", {15'h0, src == 3'h1 && !r[4]}, {15'h0, seen});
				@(posedge mclk_in);
				timer_done <= 1'b1;
				wait_done(seen);
				need = (src == 3'h1 || src == 3'h3) && r[4];
				check("switch without lock", {15'h0, !need}, {15'h0, seen});
				@(posedge mclk_in);
				pll_locked <= 1'b1;
				wait_done(seen);
				check("switch done", 16'h0001, {15'h0, seen});
				check("current after switch", {13'h0, src}, {13'h0, current_src});
				// The internal RC keeps running when it is itself the PLL's reference.
				check("rc after switch", {15'h0, k[1:0] == 2'b00 || src == 3'h1}, {15'h0, rc_en});
			end else begin
				check("current stays rc", 16'h0000, {13'h0, current_src});
				check("rc stays on", 16'h0001, {15'h0, rc_en});
			end
			reg_rd(3'h0, rd_val);
			check("control after switch", {1'b0, src, 1'b0, src, 8'h00}, rd_val & 16'hff15);
			check("core running", 16'h0001, {15'h0, core_run});
			check("target osc on", 16'h0001, {15'h0, tgt_en});
		end
		conclude();
	end
endmodule
